// file: hw/mpmb_pkg.sv
package mpmb_pkg;

  // ----------------------------------------------------------------
  // Strap field positions
  // ----------------------------------------------------------------
  localparam int STRAP_W = 16;
  localparam int PORTS = 4;
  localparam int MII_W = 4;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int ID_W = 3;
  localparam int B_DEBOUNCE = 0;
  localparam int B_IF_LO = 1;
  localparam int B_ID_LO = 4;
  localparam int B_EEPROM = 7;
  localparam int B_HOTSWAP = 9;
  localparam int B_PWRSAVE = 11;
  localparam int B_TIMEOUT = 12;
  localparam int IF_W = 3;

  // ----------------------------------------------------------------
  // Data pin positions and drive masks
  // ----------------------------------------------------------------
  localparam int B_TXCLK = 4;
  localparam int B_TXEN = 5;
  localparam int B_RXD_LO = 8;
  localparam int B_RXCLK = 12;
  localparam int B_RXDV = 13;
  localparam logic [DATA_W-1:0] OE_WIDE = 16'hFFFF;
  localparam logic [DATA_W-1:0] OE_NARROW = 16'h00FF;
  localparam logic [DATA_W-1:0] OE_MII = 16'h103F;

  // ----------------------------------------------------------------
  // Interface codes and modes
  // ----------------------------------------------------------------
  localparam logic [2:0] IF_PAR16 = 3'h0;
  localparam logic [2:0] IF_PAR8 = 3'h1;
  localparam logic [2:0] IF_SER_MII = 3'h2;
  localparam logic [2:0] IF_SER_ONLY = 3'h3;
  localparam logic [2:0] IF_UNMANAGED = 3'h7;

  typedef enum {
    MPMB_M_PAR16,
    MPMB_M_PAR8,
    MPMB_M_SER_MII,
    MPMB_M_SER_ONLY,
    MPMB_M_UNMANAGED,
    MPMB_M_RESERVED
  } mpmb_mode_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 50000000;
  localparam longint TIMEOUT_S = 5;
  localparam longint TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam int TMO_W = 28;
  localparam int IDLE_CYC = 64;
  localparam int IDLE_W = 7;
  localparam int SM_COUNT = 4;

endpackage : mpmb_pkg

// file: hw/mpmb_port_power.sv
`timescale 1ns/1ns
// Per-port idle detector driving a MAC low-power state
module mpmb_port_power
  import mpmb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic activity,
  output logic low_power
);
  logic [IDLE_W-1:0] idle_reg;

  // ----------------------------------------------------------------
  // Inactivity count and low-power state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_reg <= '0;
      low_power <= 1'b0;
    end else if (!enable || activity) begin
      idle_reg <= '0;
      low_power <= 1'b0;
    end else if (idle_reg == IDLE_W'(IDLE_CYC - 1)) begin
      low_power <= 1'b1;
    end else begin
      idle_reg <= idle_reg + IDLE_W'(1);
    end
  end

  AST_WAKE: assert property (@(posedge clk) disable iff (rst)
      activity |=> !low_power)
    else $error("port stayed in low power after activity");
endmodule : mpmb_port_power

// file: hw/mpmb_top.sv
`timescale 1ns/1ns
// Functional notes
// - Capture straps and tx-enable pins during reset
// - Strap bits 3:1 select management interface
// - Parallel16: address, strobes in; 16 data bidirectional
// - Parallel8: only data 7:0 used
// - Serial+MII: strobe, data in, data out pins
// - Serial+MII: drive MII clocks, txd, tx enable
// - Serial only: data pins unused; interrupt always
// - Code 111: address pins become SDA/SCL
// - Strap bit 0 enables strobe debounce in serial modes
// - Strap bits 6:4 give serial device id
// - Unmanaged: strap bit 7 selects EEPROM load
// - Hot-swap: tx-enable straps give module types
// - Power saving: idle port enters low power
// - Activity returns port to normal operation
// - Flag state machine busy over five seconds
// - Power-saving strap one enables, zero disables
// - Timeout strap one enables, zero disables
// - EEPROM strap one disables, zero enables loading
module mpmb_top
  import mpmb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [STRAP_W-1:0] strap_pins,
  input wire logic [PORTS-1:0] port_tx_enable_strap,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic write_n_in,
  input wire logic read_n_in,
  input wire logic cs_n_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] core_data_out,
  input wire logic core_data_drive,
  input wire logic core_irq,
  input wire logic ser_data_out,
  input wire logic [MII_W-1:0] cpu_port_txd,
  input wire logic cpu_port_tx_enable,
  input wire logic cpu_port_tx_clock,
  input wire logic cpu_port_rx_clock,
  input wire logic i2c_sda_out,
  input wire logic i2c_scl_out,
  input wire logic [PORTS-1:0] port_activity,
  input wire logic [SM_COUNT-1:0] sm_busy,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe,
  output logic read_pin_out,
  output logic read_pin_oe,
  output logic addr0_out,
  output logic addr0_oe,
  output logic addr1_out,
  output logic addr1_oe,
  output logic int_n_out,
  output logic [ADDR_W-1:0] par_addr,
  output logic par_write_n,
  output logic par_read_n,
  output logic par_cs_n,
  output logic [DATA_W-1:0] par_data,
  output logic ser_strobe,
  output logic ser_data_in,
  output logic [MII_W-1:0] cpu_port_rxd,
  output logic cpu_port_rx_valid,
  output logic i2c_sda_in,
  output logic [2:0] if_mode,
  output logic mode_parallel,
  output logic mode_serial,
  output logic mode_wide,
  output logic debounce_en,
  output logic [ID_W-1:0] serial_id,
  output logic eeprom_load_en,
  output logic hotswap_en,
  output logic [PORTS-1:0] module_type,
  output logic power_save_en,
  output logic [PORTS-1:0] port_low_power,
  output logic timeout_en,
  output logic timeout_flag,
  output logic reset_request
);
  logic [STRAP_W-1:0] strap_reg;
  logic [PORTS-1:0] txen_reg;
  logic in_reset_reg;
  mpmb_mode_t mode_next;
  logic ser_next;
  logic [SM_COUNT-1:0] tmo_hit;
  logic tmo_any;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Sample while reset holds, freeze at first edge after release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_reset_reg <= 1'b1;
    end else begin
      in_reset_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (in_reset_reg) begin
      strap_reg <= strap_pins;
      txen_reg <= port_tx_enable_strap;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    case (strap_reg[B_IF_LO +: IF_W])
      IF_PAR16: mode_next = MPMB_M_PAR16;
      IF_PAR8: mode_next = MPMB_M_PAR8;
      IF_SER_MII: mode_next = MPMB_M_SER_MII;
      IF_SER_ONLY: mode_next = MPMB_M_SER_ONLY;
      IF_UNMANAGED: mode_next = MPMB_M_UNMANAGED;
      default: mode_next = MPMB_M_RESERVED;
    endcase
  end
  assign ser_next = (mode_next == MPMB_M_SER_MII) ||
                    (mode_next == MPMB_M_SER_ONLY) ||
                    (mode_next == MPMB_M_UNMANAGED);

  // Configuration outputs, held from the captured straps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      if_mode <= IF_PAR16;
      mode_parallel <= 1'b0;
      mode_serial <= 1'b0;
      mode_wide <= 1'b0;
      debounce_en <= 1'b0;
      serial_id <= '0;
      eeprom_load_en <= 1'b0;
      hotswap_en <= 1'b0;
      module_type <= '0;
      power_save_en <= 1'b0;
      timeout_en <= 1'b0;
    end else if (!in_reset_reg) begin
      if_mode <= strap_reg[B_IF_LO +: IF_W];
      mode_parallel <= (mode_next == MPMB_M_PAR16) ||
                       (mode_next == MPMB_M_PAR8);
      mode_serial <= ser_next;
      mode_wide <= (mode_next == MPMB_M_PAR16);
      debounce_en <= ser_next && strap_reg[B_DEBOUNCE];
      serial_id <= ser_next ? strap_reg[B_ID_LO +: ID_W] : '0;
      eeprom_load_en <= (mode_next == MPMB_M_UNMANAGED) &&
                        !strap_reg[B_EEPROM];
      hotswap_en <= strap_reg[B_HOTSWAP];
      module_type <= strap_reg[B_HOTSWAP] ? txen_reg : '0;
      power_save_en <= strap_reg[B_PWRSAVE];
      timeout_en <= strap_reg[B_TIMEOUT];
    end
  end

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  // Inputs routed per mode; unused parallel strobes, selects, serial data and SDA idle high, serial strobe, address, data and MII rx idle low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      par_addr <= '0;
      par_write_n <= 1'b1;
      par_read_n <= 1'b1;
      par_cs_n <= 1'b1;
      par_data <= '0;
      ser_strobe <= 1'b0;
      ser_data_in <= 1'b1;
      cpu_port_rxd <= '0;
      cpu_port_rx_valid <= 1'b0;
      i2c_sda_in <= 1'b1;
    end else begin
      par_addr <= mode_parallel ? addr_in : '0;
      par_write_n <= mode_parallel ? write_n_in : 1'b1;
      par_read_n <= mode_parallel ? read_n_in : 1'b1;
      par_cs_n <= mode_parallel ? cs_n_in : 1'b1;
      par_data <= !mode_parallel ? '0 :
                  mode_wide ? data_in : (data_in & OE_NARROW);
      ser_strobe <= mode_serial ? write_n_in : 1'b0;
      ser_data_in <= mode_serial ? cs_n_in : 1'b1;
      cpu_port_rxd <= (if_mode == IF_SER_MII) ?
                      data_in[B_RXD_LO +: MII_W] : '0;
      cpu_port_rx_valid <= (if_mode == IF_SER_MII) && data_in[B_RXDV];
      i2c_sda_in <= (if_mode == IF_UNMANAGED) ? addr_in[0] : 1'b1;
    end
  end

  // Outputs and enables per mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= '0;
      data_oe <= '0;
      read_pin_out <= 1'b0;
      read_pin_oe <= 1'b0;
      addr0_out <= 1'b0;
      addr0_oe <= 1'b0;
      addr1_out <= 1'b0;
      addr1_oe <= 1'b0;
      int_n_out <= 1'b1;
    end else begin
      data_out <= '0;
      data_oe <= '0;
      if (mode_parallel) begin
        data_out <= core_data_out;
        data_oe <= core_data_drive ?
                   (mode_wide ? OE_WIDE : OE_NARROW) : '0;
      end else if (if_mode == IF_SER_MII) begin
        data_out[MII_W-1:0] <= cpu_port_txd;
        data_out[B_TXCLK] <= cpu_port_tx_clock;
        data_out[B_TXEN] <= cpu_port_tx_enable;
        data_out[B_RXCLK] <= cpu_port_rx_clock;
        data_oe <= OE_MII;
      end
      read_pin_out <= ser_data_out;
      read_pin_oe <= mode_serial;
      addr0_out <= i2c_sda_out;
      addr0_oe <= (if_mode == IF_UNMANAGED) && !i2c_sda_out;
      addr1_out <= i2c_scl_out;
      addr1_oe <= (if_mode == IF_UNMANAGED);
      int_n_out <= !core_irq;
    end
  end

  // ----------------------------------------------------------------
  // Port power saving
  // ----------------------------------------------------------------
  for (genvar p = 0; p < PORTS; p++) begin : g_pwr
    mpmb_port_power u_pwr (
      .clk(clk),
      .rst(rst),
      .enable(power_save_en),
      .activity(port_activity[p]),
      .low_power(port_low_power[p])
    );
  end

  // ----------------------------------------------------------------
  // Stuck-state monitor
  // ----------------------------------------------------------------
  for (genvar s = 0; s < SM_COUNT; s++) begin : g_tmo
    logic [TMO_W-1:0] cnt_reg;
    assign tmo_hit[s] = cnt_reg == TMO_W'(TIMEOUT_CYC - 1);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cnt_reg <= '0;
      end else if (!timeout_en || !sm_busy[s] || tmo_any) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + TMO_W'(1);
      end
    end
  end
  assign tmo_any = timeout_en && (|tmo_hit);

  // Single-cycle reset request and sticky flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeout_flag <= 1'b0;
      reset_request <= 1'b0;
    end else begin
      reset_request <= tmo_any;
      if (tmo_any) begin
        timeout_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_EEPROM_ONLY_UNMANAGED: assert property (
      @(posedge clk) disable iff (rst)
      eeprom_load_en |-> if_mode == IF_UNMANAGED)
    else $error("eeprom load outside unmanaged mode");
  AST_SCL_ONLY_111: assert property (@(posedge clk) disable iff (rst)
      addr1_oe |-> if_mode == IF_UNMANAGED)
    else $error("scl driven outside code 111");
  AST_PAR8_UPPER_FREE: assert property (
      @(posedge clk) disable iff (rst)
      (mode_parallel && !mode_wide) |-> (data_oe & ~OE_NARROW) == '0)
    else $error("upper data driven in 8-bit mode");
  AST_SERONLY_DATA_FREE: assert property (
      @(posedge clk) disable iff (rst)
      (if_mode == IF_SER_ONLY) |-> data_oe == '0)
    else $error("data pins driven in serial-only mode");
  AST_MII_DRIVE: assert property (@(posedge clk) disable iff (rst)
      (if_mode == IF_SER_MII && $past(if_mode) == IF_SER_MII)
      |-> data_oe == OE_MII)
    else $error("mii outputs not driven");
  AST_INT_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
      core_irq |=> !int_n_out)
    else $error("interrupt not asserted");
  AST_RESET_PULSE: assert property (@(posedge clk) disable iff (rst)
      reset_request |=> !reset_request)
    else $error("reset request longer than one cycle");
  AST_ID_SERIAL: assert property (@(posedge clk) disable iff (rst)
      (mode_parallel) |-> serial_id == '0 && !debounce_en)
    else $error("serial options set in parallel mode");
  AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (rst)
      (!in_reset_reg && !$past(in_reset_reg)) |-> $stable(strap_reg))
    else $error("straps changed after reset");
  AST_TMO_DISABLED: assert property (@(posedge clk) disable iff (rst)
      !timeout_en |=> !reset_request)
    else $error("timeout fired while disabled");

endmodule : mpmb_top

// file: verif/mpmb_host_model.sv
`timescale 1ns/1ns
// Host side of the management pins, every line pulled up
module mpmb_host_model
  import mpmb_pkg::*;
(
  input wire logic [DATA_W-1:0] dev_data,
  input wire logic [DATA_W-1:0] dev_oe,
  input wire logic [DATA_W-1:0] host_data,
  input wire logic [DATA_W-1:0] host_oe,
  input wire logic dev_sda,
  input wire logic dev_sda_oe,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic host_addr_oe,
  output logic [DATA_W-1:0] data_level,
  output logic [ADDR_W-1:0] addr_level
);
  // -------------------------------------------
  // Pin resolution
  // -------------------------------------------
  // Device first, then host, else the pull-up
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      if (dev_oe[i]) begin
        data_level[i] = dev_data[i];
      end else if (host_oe[i]) begin
        data_level[i] = host_data[i];
      end else begin
        data_level[i] = 1'b1;
      end
    end
  end

  // Address pins, pin zero shared with the SDA drive
  always_comb begin
    addr_level = host_addr_oe ? host_addr : 3'h7;
    if (dev_sda_oe) begin
      addr_level[0] = dev_sda;
    end
  end
endmodule : mpmb_host_model

// file: verif/mgmt_pin_mux_bootstrap_tb.sv
`timescale 1ns/1ns
module mgmt_pin_mux_bootstrap_tb import mpmb_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] strap_pins, data_in, core_data_out, host_data, host_oe;
  logic [3:0] port_tx_enable_strap, cpu_port_txd, port_activity, sm_busy;
  logic [2:0] addr_in, host_addr, par_addr, if_mode, serial_id;
  logic write_n_in, read_n_in, cs_n_in, core_data_drive, core_irq;
  logic ser_data_out, cpu_port_tx_enable, cpu_port_tx_clock;
  logic cpu_port_rx_clock, i2c_sda_out, i2c_scl_out, host_addr_oe;
  logic [15:0] data_out, data_oe, par_data;
  logic read_pin_out, read_pin_oe, addr0_out, addr0_oe, addr1_out;
  logic addr1_oe, int_n_out, par_write_n, par_read_n, par_cs_n;
  logic ser_strobe, ser_data_in, cpu_port_rx_valid, i2c_sda_in;
  logic mode_parallel, mode_serial, mode_wide, debounce_en;
  logic eeprom_load_en, hotswap_en, power_save_en, timeout_en;
  logic timeout_flag, reset_request;
  logic [3:0] cpu_port_rxd, module_type, port_low_power;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
  int n_mismatch = 0;
  int checks_done = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  mpmb_top u_dut (
    .clk(clk), .rst(rst), .strap_pins(strap_pins),
    .port_tx_enable_strap(port_tx_enable_strap), .addr_in(addr_in),
    .write_n_in(write_n_in), .read_n_in(read_n_in), .cs_n_in(cs_n_in),
    .data_in(data_in), .core_data_out(core_data_out),
    .core_data_drive(core_data_drive), .core_irq(core_irq),
    .ser_data_out(ser_data_out), .cpu_port_txd(cpu_port_txd),
    .cpu_port_tx_enable(cpu_port_tx_enable),
    .cpu_port_tx_clock(cpu_port_tx_clock),
    .cpu_port_rx_clock(cpu_port_rx_clock), .i2c_sda_out(i2c_sda_out),
    .i2c_scl_out(i2c_scl_out), .port_activity(port_activity),
    .sm_busy(sm_busy), .data_out(data_out), .data_oe(data_oe),
    .read_pin_out(read_pin_out), .read_pin_oe(read_pin_oe),
    .addr0_out(addr0_out), .addr0_oe(addr0_oe), .addr1_out(addr1_out),
    .addr1_oe(addr1_oe), .int_n_out(int_n_out), .par_addr(par_addr),
    .par_write_n(par_write_n), .par_read_n(par_read_n),
    .par_cs_n(par_cs_n), .par_data(par_data), .ser_strobe(ser_strobe),
    .ser_data_in(ser_data_in), .cpu_port_rxd(cpu_port_rxd),
    .cpu_port_rx_valid(cpu_port_rx_valid), .i2c_sda_in(i2c_sda_in),
    .if_mode(if_mode), .mode_parallel(mode_parallel),
    .mode_serial(mode_serial), .mode_wide(mode_wide),
    .debounce_en(debounce_en), .serial_id(serial_id),
    .eeprom_load_en(eeprom_load_en), .hotswap_en(hotswap_en),
    .module_type(module_type), .power_save_en(power_save_en),
    .port_low_power(port_low_power), .timeout_en(timeout_en),
    .timeout_flag(timeout_flag), .reset_request(reset_request)
  );

  mpmb_host_model u_host (
    .dev_data(data_out), .dev_oe(data_oe), .host_data(host_data),
    .host_oe(host_oe), .dev_sda(addr0_out), .dev_sda_oe(addr0_oe),
    .host_addr(host_addr), .host_addr_oe(host_addr_oe),
    .data_level(data_in), .addr_level(addr_in)
  );

  // -------------------------------------------
  // Shared tasks
  // -------------------------------------------
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic boot(logic [15:0] s, logic [3:0] tx);
    strap_pins = s;
    port_tx_enable_strap = tx;
    rst = 1'b1;
    step(4);
    rst = 1'b0;
    step(3);
  endtask : boot

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // -------------------------------------------
  // Test sequence
  // -------------------------------------------
  initial begin
    logic [15:0] s, eo, ed;
    logic [2:0] c;
    logic ser, par;
    {write_n_in, read_n_in, cs_n_in, core_data_drive, core_irq} = 5'h1F;
    {ser_data_out, cpu_port_tx_enable, cpu_port_tx_clock} = 3'h0;
    {cpu_port_rx_clock, i2c_sda_out, i2c_scl_out, host_addr_oe} = 4'hF;
    {core_data_out, host_data, host_oe, cpu_port_txd} = '0;
    {host_addr, port_activity, sm_busy} = {3'h0, 4'hF, 4'h0};
    for (int i = 0; i < 6; i++) begin
      c = codes[i];
      s = 16'hE000;
      s[3:1] = c;
      s[0] = i[0];
      s[6:4] = 3'(i + 1);
      s[7] = i[1];
      s[9] = i[0];
      s[11] = !i[0];
      s[12] = i[0];
      ser = (c == 3'h2) || (c == 3'h3) || (c == 3'h7);
      par = (c < 3'h2);
      eo = (c == 3'h0) ? 16'hFFFF : (c == 3'h1) ? 16'h00FF : 16'h0;
      eo = (c == 3'h2) ? 16'h103F : eo;
      ed = par ? 16'hA5C3 & eo : (c == 3'h2) ? 16'h1039 : 16'h0;
      boot(s, 4'(i + 5));
      strap_pins = ~s;
      port_tx_enable_strap = 4'h0;
      {core_irq, core_data_drive, core_data_out} = {2'h3, 16'hA5C3};
      {cpu_port_txd, cpu_port_tx_enable, cpu_port_tx_clock} = 6'h27;
      {write_n_in, cs_n_in, ser_data_out, i2c_sda_out} = 4'h2;
      read_n_in = 1'b0;
      {host_data, host_oe, host_addr} = {16'h2B00, ~eo, 3'h5};
      host_addr_oe = (c != 3'h7);
      step(2);
      chk("if_mode", if_mode, c);
      chk("mode", {mode_parallel, mode_serial, mode_wide},
          {par, ser, c == 3'h0});
      chk("debounce", debounce_en, ser & s[0]);
      chk("serial_id", serial_id, ser ? s[6:4] : 3'h0);
      chk("eeprom", eeprom_load_en, c == 3'h7 && !s[7]);
      chk("hotswap", hotswap_en, s[9]);
      chk("module", module_type, s[9] ? 4'(i + 5) : 4'h0);
      chk("feature", {power_save_en, timeout_en},
          {s[11], s[12]});
      chk("int_n", int_n_out, 1'b0);
      chk("data_oe", data_oe, eo);
      chk("data_out", data_out & data_oe, ed);
      chk("par_data", par_data, par ? 16'hA5C3 & eo : 16'h0);
      chk("par_pins", {par_addr, par_write_n, par_read_n, par_cs_n},
          par ? 6'h28 : 6'h07);
      chk("rd_oe", read_pin_oe, ser);
      chk("ser", {ser_strobe, ser_data_in, read_pin_out},
          ser ? 3'h1 : 3'h3);
      chk("mii_rx", {cpu_port_rxd, cpu_port_rx_valid},
          (c == 3'h2) ? 5'h17 : 5'h00);
      chk("i2c_oe", {addr1_oe, addr0_oe}, (c == 3'h7) ? 2'h3 : 2'h0);
      chk("i2c", {addr1_out, addr0_out, i2c_sda_in},
          (c == 3'h7) ? 3'h4 : 3'h5);
      core_irq = 1'b0;
      step(1);
      chk("int_n", int_n_out, 1'b1);
    end
    boot(16'hE800, 4'h0);
    port_activity = 4'h0;
    step(IDLE_CYC - 8);
    chk("low_power", port_low_power, 4'h0);
    step(10);
    chk("low_power", port_low_power, 4'hF);
    port_activity = 4'h1;
    step(1);
    chk("wake", port_low_power, 4'hE);
    boot(16'hF000, 4'h0);
    {port_activity, sm_busy} = 8'h0F;
    step(IDLE_CYC + 2);
    chk("low_power", port_low_power, 4'h0);
    chk("timeout", {timeout_flag, reset_request}, 2'h0);
    print_verdict();
  end

  // Watchdog against a hung run
  initial begin
    #(20 * 5000);
    n_mismatch++;
    print_verdict();
  end
endmodule : mgmt_pin_mux_bootstrap_tb
